// *** hdl/cell_policy.sv ***
/*
  Per-cell policy derived from the polarity snapshot of a scan.
  Assumes the snapshot is stable for the whole scan.
*/
`timescale 1ns/100ps
`include "scan_cfg_defs.svh"
module cell_policy
  import scan_cfg_pkg::*;
#(
  parameter int CELLS = `CELL_COUNT
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  cell_cfg_type   cfg_i,
  input  wire logic      balance_diag_i,
  output cell_policy_type policy_o
);
  // one flop set per cell channel
  for (genvar c = 0; c < CELLS; c++) begin : g_cell
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        policy_o.stats_include[c]     <= 1'b0;
        policy_o.fault_mask[c]        <= 1'b0;
        policy_o.bipolar_threshold[c] <= 1'b0;
        policy_o.comparator_enable[c] <= 1'b0;
      end else begin
        policy_o.stats_include[c] <= cfg_i.bipolar[c] == cfg_i.stats_population_mode;
        policy_o.fault_mask[c] <= cfg_i.bipolar[c] & balance_diag_i;
        policy_o.bipolar_threshold[c] <= cfg_i.bipolar[c];
        policy_o.comparator_enable[c] <= ~cfg_i.bipolar[c];
      end
    end
  end
endmodule

// *** hdl/scan_config_bank.sv ***
/*
  Scan configuration bank: cell polarity, auxiliary reference and
  settle-time registers behind a classic Wishbone slave, plus the
  scan sequencer that applies them at the start of every scan.
  Assumes the measurement engine gives a one-cycle scan request and a
  one-cycle done pulse, and that all inputs are synchronous to clk_i.
*/
`timescale 1ns/100ps
`include "scan_cfg_defs.svh"
module scan_config_bank
  import scan_cfg_pkg::*;
#(
  parameter int SETTLE_STEP_CYCLES = `SETTLE_STEP_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // classic wishbone slave
  input  wire logic [8:0]             adr_i,
  input  wire logic [31:0]            dat_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic                   we_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  output logic [31:0]                 dat_o,
  output logic                        ack_o,
  // measurement engine side
  input  wire logic                   scan_req_i,
  input  wire logic                   scan_done_i,
  input  wire logic                   balance_diag_scan_i,
  input  wire logic                   other_meas_active_i,
  output logic                        settling_o,
  output logic                        measure_start_o,
  output logic                        charge_pump_refresh_o,
  output logic                        thermistor_bias_pin_o,
  output logic                        stats_population_mode_o,
  output logic [`CELL_COUNT-1:0]      cell_bipolar_o,
  output cell_policy_type             cell_policy_o,
  output logic [`AUX_COUNT-1:0]       aux_absolute_ref_o
);

  // register contents
  logic [15:0]           cell_polarity_select;
  logic [15:0]           aux_reference_select;
  logic [15:0]           aux_settle_time;
  logic [15:0]           aux_port_config;

  // bus decode
  logic                  bus_req;
  logic                  wr_en;
  logic                  rd_en;
  logic [15:0]           next_rd_data;

  // sequencer
  scan_state_type        state;
  logic                  timer_start;
  logic                  timer_busy;
  logic                  timer_done;
  cell_cfg_type          cell_snap;
  logic                  diag_snap;
  logic [`SETTLE_WIDTH-1:0] settle_snap;
  logic [`AUX_COUNT-1:0] next_aux_ref;
  logic                  bias_auto_on;

  // named views of the loose port bits
  logic [`AUX_COUNT-1:0] aux_port_gpio_enable;
  logic                  aux_pins_twowire_enable;
  logic [1:0]            bias_mode;

  // true when the word address selects register idx
  function automatic logic reg_hit(input logic [8:0] adr,
                                   input logic [6:0] idx);
    reg_hit = adr[8:2] == idx;
  endfunction

  // byte-lane merge of the low 16 bits, masked to the writable field
  function automatic logic [15:0] lane_write(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  sel,
                                             input logic [15:0] mask);
    logic [15:0] merged;
    merged = old;
    if (sel[0]) begin
      merged[7:0] = data[7:0];
    end
    if (sel[1]) begin
      merged[15:8] = data[15:8];
    end
    lane_write = merged & mask;
  endfunction

  // writable field masks; reserved bits stay zero and read as zero
  localparam logic [15:0] POL_MASK =
    (16'h0001 << `POL_MODE_BIT) | ((16'h0001 << (`POL_CELL_MSB + 1)) - 16'h0001);
  localparam logic [15:0] REF_MASK =
    (16'h0001 << (`AUX_REF_MSB + 1)) - 16'h0001;
  localparam logic [15:0] SETTLE_MASK =
    (16'h0001 << (`SETTLE_MSB + 1)) - 16'h0001;
  localparam logic [15:0] PORT_MASK =
    ((16'h0001 << (`PORT_GPIO_MSB + 1)) - 16'h0001) |
    (16'h0001 << `PORT_TWOWIRE_BIT) |
    (16'h0003 << `PORT_BIAS_LSB);

  assign aux_port_gpio_enable    = aux_port_config[`PORT_GPIO_MSB:0];
  assign aux_pins_twowire_enable = aux_port_config[`PORT_TWOWIRE_BIT];
  assign bias_mode               = aux_port_config[`PORT_BIAS_MSB:`PORT_BIAS_LSB];

  // a request is taken once; ack low in between keeps it single
  assign bus_req = cyc_i & stb_i & ~ack_o;
  // writes land at the ack edge, the one edge at which the master commits
  assign wr_en   = cyc_i & stb_i & we_i & ack_o;
  assign rd_en   = bus_req & ~we_i;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  // polarity register, cells unipolar at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_polarity_select <= `RST_CELL_POLARITY;
    end else if (wr_en && reg_hit(adr_i, `IDX_CELL_POLARITY)) begin
      cell_polarity_select <= lane_write(cell_polarity_select, dat_i, sel_i, POL_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_reference_select <= `RST_AUX_REFERENCE;
    end else if (wr_en && reg_hit(adr_i, `IDX_AUX_REFERENCE)) begin
      aux_reference_select <= lane_write(aux_reference_select, dat_i, sel_i, REF_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_settle_time <= `RST_AUX_SETTLE;
    end else if (wr_en && reg_hit(adr_i, `IDX_AUX_SETTLE)) begin
      aux_settle_time <= lane_write(aux_settle_time, dat_i, sel_i, SETTLE_MASK);
    end
  end

  // port configuration: gpio enables, two-wire mode, bias mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_port_config <= `RST_AUX_PORT_CFG;
    end else if (wr_en && reg_hit(adr_i, `IDX_AUX_PORT_CFG)) begin
      aux_port_config <= lane_write(aux_port_config, dat_i, sel_i, PORT_MASK);
    end
  end

  // read mux; unmapped words answer zero so the bus never hangs
  always_comb begin
    next_rd_data = 16'h0000;
    if (reg_hit(adr_i, `IDX_CELL_POLARITY)) begin
      next_rd_data = cell_polarity_select;
    end else if (reg_hit(adr_i, `IDX_AUX_REFERENCE)) begin
      next_rd_data = aux_reference_select;
    end else if (reg_hit(adr_i, `IDX_AUX_SETTLE)) begin
      next_rd_data = aux_settle_time;
    end else if (reg_hit(adr_i, `IDX_AUX_PORT_CFG)) begin
      next_rd_data = aux_port_config;
    end else if (reg_hit(adr_i, `IDX_SCAN_STATUS)) begin
      next_rd_data = {12'h000, charge_pump_refresh_o, thermistor_bias_pin_o,
                      state == ST_MEASURE, state == ST_SETTLE};
    end
  end

  // read data registered with the ack; upper half always zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      dat_o <= {16'h0000, next_rd_data};
    end
  end

  // effective aux reference with overrides applied
  always_comb begin
    next_aux_ref = aux_reference_select[`AUX_REF_MSB:0] & ~aux_port_gpio_enable;
    if (aux_pins_twowire_enable) begin
      next_aux_ref = next_aux_ref & ~`TWOWIRE_PIN_MASK;
    end
  end

  // a scan request seen in idle starts a settle
  assign timer_start = (state == ST_IDLE) & scan_req_i;

  // scan sequencer; requests during a scan are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (scan_req_i) begin
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (timer_done) begin
            state <= ST_MEASURE;
          end
        end
        ST_MEASURE: begin
          if (scan_done_i) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_snap   <= '0;
      diag_snap   <= 1'b0;
      settle_snap <= '0;
    end else if (timer_start) begin
      cell_snap.stats_population_mode <= cell_polarity_select[`POL_MODE_BIT];
      cell_snap.bipolar     <= cell_polarity_select[`POL_CELL_MSB:0];
      diag_snap             <= balance_diag_scan_i;
      settle_snap           <= aux_settle_time[`SETTLE_MSB:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_absolute_ref_o <= '0;
    end else if (timer_start) begin
      aux_absolute_ref_o <= next_aux_ref;
    end
  end

  // the snapshot straight out, one flop stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stats_population_mode_o <= 1'b0;
      cell_bipolar_o          <= '0;
    end else begin
      stats_population_mode_o <= cell_snap.stats_population_mode;
      cell_bipolar_o          <= cell_snap.bipolar;
    end
  end

  settle_timer #(
    .STEP_CYCLES (SETTLE_STEP_CYCLES)
  ) u_settle (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (timer_start),
    .count_i (aux_settle_time[`SETTLE_MSB:0]),
    .busy_o  (timer_busy),
    .done_o  (timer_done)
  );

  // per-cell policy from the frozen polarity
  cell_policy #(
    .CELLS (`CELL_COUNT)
  ) u_policy (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .cfg_i          (cell_snap),
    .balance_diag_i (diag_snap),
    .policy_o       (cell_policy_o)
  );

  // sequencer strobes toward the engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settling_o      <= 1'b0;
      measure_start_o <= 1'b0;
    end else begin
      settling_o      <= timer_busy;
      measure_start_o <= (state == ST_SETTLE) & timer_done;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_pump_refresh_o <= 1'b0;
    end else begin
      charge_pump_refresh_o <= timer_busy & ~other_meas_active_i;
    end
  end

  assign bias_auto_on = (state != ST_IDLE);

  // manual modes override; auto keeps the pin quiet between scans
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thermistor_bias_pin_o <= 1'b0;
    end else begin
      case (bias_mode)
        `BIAS_MANUAL_OFF: thermistor_bias_pin_o <= 1'b0;
        `BIAS_MANUAL_ON:  thermistor_bias_pin_o <= 1'b1;
        default:          thermistor_bias_pin_o <= bias_auto_on;
      endcase
    end
  end

endmodule

// *** hdl/settle_timer.sv ***
/*
  Counts the auxiliary settling interval in steps of a fixed length.
  Assumes start_i is a one-cycle pulse given while not busy.
*/
`timescale 1ns/100ps
`include "scan_cfg_defs.svh"
module settle_timer #(
  parameter int STEP_CYCLES = `SETTLE_STEP_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     start_i,
  input  wire logic [`SETTLE_WIDTH-1:0] count_i,
  output logic                          busy_o,
  output logic                          done_o
);
  localparam int SW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  logic [SW-1:0]            step;
  logic [`SETTLE_WIDTH-1:0] remaining;

  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy_o    <= 1'b0;
      step      <= '0;
      remaining <= '0;
    end else if (start_i) begin
      busy_o    <= 1'b1;
      step      <= '0;
      remaining <= count_i;
    end else if (busy_o) begin
      if (remaining == '0) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end else if (step == SW'(STEP_CYCLES - 1)) begin
        step      <= '0;
        remaining <= remaining - 1'b1;
      end else begin
        step <= step + 1'b1;
      end
    end
  end
endmodule

// *** inc/scan_cfg_defs.svh ***
/*
  Constants of the scan configuration bank: register indices, field
  positions, reset values and settling timing.
  Assumes a 40 MHz clock and a Wishbone bus of 32-bit words.
*/
// Functional notes
// - bit 15 picks unipolar or bipolar statistics population
// - bits 13:0 select cell unipolar/bipolar, default unipolar
// - bipolar cells fault masked in balance-switch diagnostic
// - bipolar cells use bipolar over/under thresholds
// - bipolar cells excluded from comparator scans
// - bits 5:0 pick ratiometric or absolute aux reference
// - aux reference bit also selects threshold set (here it only drives aux_absolute_ref_o, no threshold set)
// - gpio enable overrides reference bit, readback kept
// - two-wire mode overrides aux bits 1:0 too
// - settle time is field times 6 us
// - settle field resets to zero
// - settle interval starts every requested scan
// - auto mode drives thermistor bias from acquisition start
// - charge pump refreshed during idle settle interval
`ifndef SCAN_CFG_DEFS_SVH
`define SCAN_CFG_DEFS_SVH

`define CELL_COUNT          14
`define AUX_COUNT           6
`define SETTLE_WIDTH        10

// register indices; byte address is four times the index
`define IDX_CELL_POLARITY   7'h5f
`define IDX_AUX_REFERENCE   7'h60
`define IDX_AUX_SETTLE      7'h61
`define IDX_AUX_PORT_CFG    7'h70
`define IDX_SCAN_STATUS     7'h71

// field positions
`define POL_MODE_BIT        15
`define POL_CELL_MSB        13
`define AUX_REF_MSB         5
`define SETTLE_MSB          9
`define PORT_GPIO_MSB       5
`define PORT_TWOWIRE_BIT    6
`define PORT_BIAS_LSB       8
`define PORT_BIAS_MSB       9
`define TWOWIRE_PIN_MASK    6'h03

// reset values
`define RST_CELL_POLARITY   16'h0000
`define RST_AUX_REFERENCE   16'h0000
`define RST_AUX_SETTLE      16'h0000
`define RST_AUX_PORT_CFG    16'h0000

// bias modes
`define BIAS_MANUAL_OFF     2'h2
`define BIAS_MANUAL_ON      2'h3

// timing: one settle step
`define SETTLE_STEP_NS      6000
`define CLK_PERIOD_NS       25
`define SETTLE_STEP_CYCLES  ((`SETTLE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** inc/scan_cfg_pkg.sv ***
/*
  Types shared by the scan configuration bank and its submodules.
  Assumes scan_cfg_defs.svh on the include path.
*/
`include "scan_cfg_defs.svh"
package scan_cfg_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_MEASURE} scan_state_type;

  typedef struct packed {
    logic                    stats_population_mode;
    logic [`CELL_COUNT-1:0]  bipolar;
  } cell_cfg_type;

  typedef struct packed {
    logic [`CELL_COUNT-1:0]  stats_include;
    logic [`CELL_COUNT-1:0]  fault_mask;
    logic [`CELL_COUNT-1:0]  bipolar_threshold;
    logic [`CELL_COUNT-1:0]  comparator_enable;
  } cell_policy_type;
endpackage

// *** tb/scan_config_monitor.sv ***
/* checker for the scan configuration bank.
   assumes it is bound to the bank's top ports, one clock domain. */
`timescale 1ns/100ps
`include "scan_cfg_defs.svh"
module scan_config_monitor
  import scan_cfg_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  input wire logic                  scan_req_i,
  input wire logic                  scan_done_i,
  input wire logic                  other_meas_active_i,
  input wire logic                  settling_o,
  input wire logic                  measure_start_o,
  input wire logic                  charge_pump_refresh_o,
  input wire logic                  stats_population_mode_o,
  input wire logic [`CELL_COUNT-1:0] cell_bipolar_o,
  input cell_policy_type            cell_policy_o,
  input wire logic [`AUX_COUNT-1:0] aux_absolute_ref_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic active;
  logic meas;
  logic take;

  // shadow of the sequencer: a request only counts while idle
  assign take = scan_req_i && !active;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= 1'b0;
      meas   <= 1'b0;
    end else begin
      // done counts from the cycle in which the start pulse stands
      if (take) begin
        active <= 1'b1;
      end else if ((meas || measure_start_o) && scan_done_i) begin
        active <= 1'b0;
      end
      if ((meas || measure_start_o) && scan_done_i) begin
        meas <= 1'b0;
      end else if (measure_start_o) begin
        meas <= 1'b1;
      end
    end
  end

  sequence quiet2;
    !take ##1 !take;
  endsequence
  sequence settle_end;
    $fell(settling_o);
  endsequence

  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_upper_zero: assert property (dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_req_settles: assert property (take |-> ##2 settling_o)
    else $error("settling did not follow request");
  a_start_after: assert property (settle_end |-> measure_start_o)
    else $error("measurement did not start after settling");
  a_start_only: assert property (measure_start_o |-> $past(settling_o) && !settling_o)
    else $error("measurement start without settling");
  a_pump_refresh: assert property (charge_pump_refresh_o ==
    (settling_o && !$past(other_meas_active_i))) else $error("charge pump refresh wrong");
  // a change mid-scan must not reach the snapshots
  a_snap_hold: assert property (quiet2 |=> $stable(cell_bipolar_o) &&
    $stable(stats_population_mode_o) && $stable(aux_absolute_ref_o))
    else $error("snapshot changed outside request");
  a_policy_map: assert property (!$past(rst_i) |->
    cell_policy_o.comparator_enable == ~cell_bipolar_o &&
    cell_policy_o.bipolar_threshold == cell_bipolar_o &&
    (cell_policy_o.fault_mask & ~cell_bipolar_o) == '0 &&
    cell_policy_o.stats_include ==
    ~(cell_bipolar_o ^ {`CELL_COUNT{stats_population_mode_o}}))
    else $error("cell policy does not follow polarity");
endmodule

bind scan_config_bank scan_config_monitor i_scan_config_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
  .ack_o(ack_o), .scan_req_i(scan_req_i), .scan_done_i(scan_done_i),
  .other_meas_active_i(other_meas_active_i), .settling_o(settling_o),
  .measure_start_o(measure_start_o), .charge_pump_refresh_o(charge_pump_refresh_o),
  .stats_population_mode_o(stats_population_mode_o), .cell_bipolar_o(cell_bipolar_o),
  .cell_policy_o(cell_policy_o), .aux_absolute_ref_o(aux_absolute_ref_o));

// *** tb/tb_scan_config_bank.sv ***
/* bench for the scan configuration bank: wishbone register access
   and scan sequencing. assumes a settle step shortened to 4 cycles. */
`timescale 1ns/100ps
module tb_scan_config_bank
  import scan_cfg_pkg::*;
;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic [8:0]      adr_i = 9'h000;
  logic [31:0]     dat_i = 32'h0;
  logic [3:0]      sel_i = 4'h0;
  logic            we_i = 1'b0;
  logic            cyc_i = 1'b0;
  logic            stb_i = 1'b0;
  logic            scan_req_i = 1'b0;
  logic            scan_done_i = 1'b0;
  logic            balance_diag_scan_i = 1'b0;
  logic            other_meas_active_i = 1'b0;
  logic [31:0]     dat_o;
  logic            ack_o, settling_o, measure_start_o, charge_pump_refresh_o;
  logic            thermistor_bias_pin_o, stats_population_mode_o;
  logic [13:0]     cell_bipolar_o;
  cell_policy_type cell_policy_o;
  logic [5:0]      aux_absolute_ref_o;
  int              num_errors = 0;
  int              total_checks = 0;
  int              cycles = 0;

  scan_config_bank #(.SETTLE_STEP_CYCLES(4)) i_scan_config_bank (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .scan_req_i(scan_req_i), .scan_done_i(scan_done_i),
    .balance_diag_scan_i(balance_diag_scan_i), .other_meas_active_i(other_meas_active_i),
    .settling_o(settling_o), .measure_start_o(measure_start_o),
    .charge_pump_refresh_o(charge_pump_refresh_o),
    .thermistor_bias_pin_o(thermistor_bias_pin_o),
    .stats_population_mode_o(stats_population_mode_o), .cell_bipolar_o(cell_bipolar_o),
    .cell_policy_o(cell_policy_o), .aux_absolute_ref_o(aux_absolute_ref_o));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d of %0d checks", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic [6:0] idx, input logic w, input logic [15:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk_i);
    adr_i <= {idx, 2'b00};
    we_i <= w;
    dat_i <= {16'h0000, d};
    sel_i <= s;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] r;
    wb(idx, 1'b1, d, s, r);
  endtask

  task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    wb(idx, 1'b0, 16'h0000, 4'hf, r);
    check(r, exp);
  endtask

  // request a scan; a stray request while busy must be dropped
  task automatic run_scan(input logic dg, input logic ot, input int n);
    int k;
    k = 0;
    @(posedge clk_i);
    scan_req_i <= 1'b1;
    balance_diag_scan_i <= dg;
    other_meas_active_i <= ot;
    @(posedge clk_i);
    scan_req_i <= 1'b0;
    do begin
      @(posedge clk_i);
      k++;
      scan_req_i <= (k == 2) && (n > 0);
      if (k == 2) begin
        check(settling_o, 1'b1);
        check(charge_pump_refresh_o, !ot);
      end
    end while (measure_start_o !== 1'b1);
    // the start pulse is seen one edge after it is launched
    check(k, n * 4 + 3);
    check(thermistor_bias_pin_o, 1'b1);
  endtask

  task automatic end_scan;
    @(posedge clk_i);
    scan_done_i <= 1'b1;
    other_meas_active_i <= 1'b0;
    @(posedge clk_i);
    scan_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(thermistor_bias_pin_o, 1'b0);
  endtask

  // hang guard: the longest scan is about 4100 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim;
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(7'h5f, 32'h0);
    rd(7'h60, 32'h0);
    rd(7'h61, 32'h0);
    // reserved bits drop, byte lanes separate, unmapped reads zero
    wr(7'h5f, 16'hffff, 4'h3);
    rd(7'h5f, 32'hbfff);
    wr(7'h5f, 16'h0000, 4'h1);
    rd(7'h5f, 32'hbf00);
    wr(7'h60, 16'hffff, 4'h3);
    rd(7'h60, 32'h003f);
    wr(7'h61, 16'hffff, 4'h3);
    rd(7'h61, 32'h03ff);
    wr(7'h10, 16'hffff, 4'h3);
    rd(7'h10, 32'h0);
    // bipolar cells 0 and 2, bipolar statistics, diagnostic scan
    wr(7'h5f, 16'h8005, 4'h3);
    wr(7'h60, 16'h002a, 4'h3);
    wr(7'h61, 16'h0003, 4'h3);
    run_scan(1'b1, 1'b0, 3);
    check({stats_population_mode_o, cell_bipolar_o}, {1'b1, 14'h0005});
    check(cell_policy_o, {14'h0005, 14'h0005, 14'h0005, 14'h3ffa});
    check(aux_absolute_ref_o, 6'h2a);
    wr(7'h5f, 16'h0000, 4'h3);
    check(cell_bipolar_o, 14'h0005);
    end_scan;
    // gpio on port 5 and two-wire pins mask the reference bits
    wr(7'h60, 16'h003f, 4'h3);
    wr(7'h70, 16'h0060, 4'h3);
    wr(7'h61, 16'h0000, 4'h3);
    run_scan(1'b0, 1'b1, 0);
    check(aux_absolute_ref_o, 6'h1c);
    check(cell_policy_o, {14'h3fff, 14'h0000, 14'h0000, 14'h3fff});
    rd(7'h71, 32'h0006);
    rd(7'h60, 32'h003f);
    end_scan;
    // manual bias modes override the automatic pin control
    wr(7'h70, 16'h0300, 4'h3);
    rd(7'h71, 32'h0004);
    check(thermistor_bias_pin_o, 1'b1);
    wr(7'h70, 16'h0200, 4'h3);
    rd(7'h71, 32'h0000);
    check(thermistor_bias_pin_o, 1'b0);
    // longest settle field
    wr(7'h70, 16'h0000, 4'h3);
    wr(7'h61, 16'h03ff, 4'h3);
    run_scan(1'b0, 1'b0, 1023);
    end_scan;
    // a reset in mid-run brings the settle field back to zero
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(7'h61, 32'h0);
    check(cell_policy_o.comparator_enable, 14'h3fff);
    end_sim;
  end
endmodule
